//--- hcmp_comparator.sv
// one ip/udp/ach header comparator stage with its wishbone register file
// assumes the previous stage hands over a whole header window, byte 0 first
//
// The Wishbone interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - two-bit mode: ipv4, ipv6, generic32, generic128
// - ip modes check version 4 or 6
// - generic modes skip the version check
// - ipv4 needs zero fragment offset, clear mf
// - set a compares protocol or next-header byte
// - mask one compares bit, zero ignores it
// - all-zero mask disables a match set
// - set a starts at five-bit header offset
// - set b compares 64 bits at seven-bit offset
// - programmed byte count gives header length
// - three-bit following stage selector, some reserved
// - five-bit offset locates the flow field
// - zero-checksum setting clears two checksum bytes
// - fixup setting rewrites last two payload bytes
// - ipv4 checksum position forwarded to later stage
// - two-bit checksum length, normally two bytes
// - ip flows match source or destination address
// - generic flows match 32/128 bits, no direction
// - flow selector: source, destination or either
// - ipv4 uses upper 32 bits of flow match
// - flow applies only on enabled channels
module hcmp_comparator
  import hcmp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic hdr_valid_i,
  input wire logic [HDR_W-1:0] hdr_i,
  input wire logic [$clog2(CHANS)-1:0] chan_i,
  output hcmp_res_t res_o
);
  // ==========================================================
  // state
  typedef struct packed {
    hcmp_cfg_t cfg;
    hcmp_flow_t [FLOWS-1:0] flow;
    hcmp_res_t res;
    logic ack;
    logic [31:0] dat;
  } hcmp_state_t;

  hcmp_state_t st_reg;
  hcmp_state_t st_next;

  // ==========================================================
  // helpers
  // gather n header bytes from off, first byte ends up most significant
  function automatic logic [127:0] pick(input logic [HDR_W-1:0] h, input int off, input int n);
    logic [127:0] r;
    r = '0;
    for (int i = 0; i < WIDE_BYTES; i++) begin
      // bytes past the window shift in as zero, so the field keeps its alignment
      if (i < n) begin
        r = {r[119:0], (off + i < HDR_BYTES) ? h[8*(off+i) +: 8] : 8'h00};
      end
    end
    return r;
  endfunction

  // masked equality; a zero mask always passes, which disables the set
  function automatic logic mcmp(input logic [127:0] a, input logic [127:0] m, input logic [127:0] k);
    return ((a ^ m) & k) == '0;
  endfunction

  // byte-lane merge of a write into the current word
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  // ==========================================================
  // protocol checks on the presented header
  logic [7:0] byte0;
  logic [7:0] frag_hi;
  logic [7:0] frag_lo;
  logic [127:0] pa_raw;
  logic [127:0] pb_raw;
  logic ver_ok;
  logic frag_ok;
  logic a_ok;
  logic b_ok;
  logic proto_ok;
  logic next_ok;
  logic is_ip;
  logic wide;

  assign byte0 = hdr_i[7:0];
  assign frag_hi = hdr_i[8*FRAG_BYTE +: 8];
  assign frag_lo = hdr_i[8*(FRAG_BYTE+1) +: 8];
  assign is_ip = (st_reg.cfg.mode == MODE_V4) || (st_reg.cfg.mode == MODE_V6);
  assign wide = (st_reg.cfg.mode == MODE_V6) || (st_reg.cfg.mode == MODE_G128);

  // version is checked implicitly only in the two ip modes
  always_comb begin
    unique case (st_reg.cfg.mode)
      MODE_V4: ver_ok = byte0[7:4] == VER_V4;
      MODE_V6: ver_ok = byte0[7:4] == VER_V6;
      default: ver_ok = 1'b1;
    endcase
  end

  // fragments are refused: mf clear and a zero 13-bit offset
  assign frag_ok = (st_reg.cfg.mode != MODE_V4) || (!frag_hi[MF_BIT] && frag_hi[4:0] == 5'h00 && frag_lo == 8'h00);

  // the two match/mask sets
  assign pa_raw = pick(hdr_i, int'(st_reg.cfg.pos_a), 1);
  assign pb_raw = pick(hdr_i, int'(st_reg.cfg.pos_b), B_BYTES);
  assign a_ok = mcmp({120'h0, pa_raw[7:0]}, {120'h0, st_reg.cfg.match_a}, {120'h0, st_reg.cfg.mask_a});
  assign b_ok = mcmp({64'h0, pb_raw[63:0]}, {64'h0, st_reg.cfg.match_b}, {64'h0, st_reg.cfg.mask_b});
  assign proto_ok = ver_ok && frag_ok && a_ok && b_ok;

  // reserved stage codes are flagged rather than passed on silently
  always_comb begin
    unique case (st_reg.cfg.next_sel)
      3'h1, 3'h2, 3'h3, 3'h5: next_ok = 1'b1;
      default: next_ok = 1'b0;
    endcase
  end

  // ==========================================================
  // per-flow address or generic field match
  logic [FLOWS-1:0] flow_hit;

  genvar g;
  generate
    for (g = 0; g < FLOWS; g++) begin : g_flow
      logic [127:0] src;
      logic [127:0] dst;
      logic src_ok;
      logic dst_ok;
      logic fl_ok;
      int n;
      assign n = wide ? WIDE_BYTES : NARROW_BYTES;
      assign src = pick(hdr_i, int'(st_reg.cfg.flow_pos), n);
      assign dst = pick(hdr_i, int'(st_reg.cfg.flow_pos) + n, n);
      // narrow matches use only the top word of match and mask
      assign src_ok = wide ? mcmp(src, st_reg.flow[g].match, st_reg.flow[g].mask)
        : mcmp({src[31:0], 96'h0}, st_reg.flow[g].match, {st_reg.flow[g].mask[127:96], 96'h0});
      assign dst_ok = wide ? mcmp(dst, st_reg.flow[g].match, st_reg.flow[g].mask)
        : mcmp({dst[31:0], 96'h0}, st_reg.flow[g].match, {st_reg.flow[g].mask[127:96], 96'h0});
      // generic modes have no direction, so only the field at the offset counts
      always_comb begin
        if (!is_ip) begin
          fl_ok = src_ok;
        end else begin
          unique case (st_reg.flow[g].sel)
            SEL_SRC: fl_ok = src_ok;
            SEL_DST: fl_ok = dst_ok;
            SEL_ANY: fl_ok = src_ok || dst_ok;
            default: fl_ok = 1'b0;
          endcase
        end
      end
      assign flow_hit[g] = st_reg.flow[g].ena && st_reg.flow[g].chan_en[chan_i] && fl_ok && proto_ok;
    end
  endgenerate

  // ==========================================================
  // register read view, also the base for byte-lane writes
  logic [31:0] rd;
  logic [1:0] fi;
  logic [3:0] fw;
  logic in_flow;

  assign fi = wb_adr_i[7:6] - 2'h1;
  assign fw = wb_adr_i[5:2];
  assign in_flow = wb_adr_i[7:6] != 2'h0 && int'(fi) < FLOWS;

  always_comb begin
    rd = 32'h0;
    if (in_flow) begin
      if (fw == 4'h0) begin
        rd[F_ENA] = st_reg.flow[fi].ena;
        rd[F_SEL +: 2] = st_reg.flow[fi].sel;
        rd[F_CHAN +: CHANS] = st_reg.flow[fi].chan_en;
      end else if (fw >= 4'(F_MATCH_W) && fw < 4'(F_MATCH_W + 4)) begin
        rd = st_reg.flow[fi].match[32*(fw-4'(F_MATCH_W)) +: 32];
      end else if (fw >= 4'(F_MASK_W) && fw < 4'(F_MASK_W + 4)) begin
        rd = st_reg.flow[fi].mask[32*(fw-4'(F_MASK_W)) +: 32];
      end
    end else begin
      unique case (wb_adr_i)
        A_CTRL: begin
          rd[C_MODE +: 2] = st_reg.cfg.mode;
          rd[C_ZERO] = st_reg.cfg.zero_en;
          rd[C_FIX] = st_reg.cfg.fixup_en;
          rd[C_SLEN +: 2] = st_reg.cfg.sum_len;
          rd[C_NEXT +: 3] = st_reg.cfg.next_sel;
        end
        A_POS: begin
          rd[P_A +: 5] = st_reg.cfg.pos_a;
          rd[P_B +: 7] = st_reg.cfg.pos_b;
          rd[P_FLOW +: 5] = st_reg.cfg.flow_pos;
          rd[P_HLEN +: 8] = st_reg.cfg.hdr_len;
        end
        A_PRA: begin
          rd[R_MATCH +: 8] = st_reg.cfg.match_a;
          rd[R_MASK +: 8] = st_reg.cfg.mask_a;
        end
        A_SUMP: rd[7:0] = st_reg.cfg.sum_pos;
        A_MBL: rd = st_reg.cfg.match_b[31:0];
        A_MBH: rd = st_reg.cfg.match_b[63:32];
        A_KBL: rd = st_reg.cfg.mask_b[31:0];
        A_KBH: rd = st_reg.cfg.mask_b[63:32];
        A_STAT: begin
          rd[S_VALID] = st_reg.res.valid;
          rd[S_PROTO] = st_reg.res.proto_ok;
          rd[S_NEXT] = st_reg.res.next_ok;
          rd[S_HIT +: FLOWS] = st_reg.res.hit;
        end
        default: rd = 32'h0;
      endcase
    end
  end

  // ==========================================================
  // next state: bus writes, ack and result capture
  logic req;
  logic [31:0] wv;

  assign req = wb_cyc_i && wb_stb_i && !st_reg.ack;
  assign wv = wmerge(rd, wb_dat_i, wb_sel_i);

  always_comb begin
    st_next = st_reg;
    st_next.ack = req;
    if (req) begin
      st_next.dat = rd;
    end
    if (req && wb_we_i) begin
      if (in_flow) begin
        if (fw == 4'h0) begin
          st_next.flow[fi].ena = wv[F_ENA];
          st_next.flow[fi].sel = wv[F_SEL +: 2];
          st_next.flow[fi].chan_en = wv[F_CHAN +: CHANS];
        end else if (fw >= 4'(F_MATCH_W) && fw < 4'(F_MATCH_W + 4)) begin
          st_next.flow[fi].match[32*(fw-4'(F_MATCH_W)) +: 32] = wv;
        end else if (fw >= 4'(F_MASK_W) && fw < 4'(F_MASK_W + 4)) begin
          st_next.flow[fi].mask[32*(fw-4'(F_MASK_W)) +: 32] = wv;
        end
      end else begin
        unique case (wb_adr_i)
          A_CTRL: begin
            st_next.cfg.mode = wv[C_MODE +: 2];
            st_next.cfg.zero_en = wv[C_ZERO];
            st_next.cfg.fixup_en = wv[C_FIX];
            st_next.cfg.sum_len = wv[C_SLEN +: 2];
            st_next.cfg.next_sel = wv[C_NEXT +: 3];
          end
          A_POS: begin
            st_next.cfg.pos_a = wv[P_A +: 5];
            st_next.cfg.pos_b = wv[P_B +: 7];
            st_next.cfg.flow_pos = wv[P_FLOW +: 5];
            st_next.cfg.hdr_len = wv[P_HLEN +: 8];
          end
          A_PRA: begin
            st_next.cfg.match_a = wv[R_MATCH +: 8];
            st_next.cfg.mask_a = wv[R_MASK +: 8];
          end
          A_SUMP: st_next.cfg.sum_pos = wv[7:0];
          A_MBL: st_next.cfg.match_b[31:0] = wv;
          A_MBH: st_next.cfg.match_b[63:32] = wv;
          A_KBL: st_next.cfg.mask_b[31:0] = wv;
          A_KBH: st_next.cfg.mask_b[63:32] = wv;
          default: ;
        endcase
      end
    end
    // result: one pulse of valid per header, fields hold until the next
    st_next.res.valid = hdr_valid_i;
    if (hdr_valid_i) begin
      st_next.res.proto_ok = proto_ok;
      st_next.res.next_ok = next_ok;
      st_next.res.hit = flow_hit;
      st_next.res.hdr_len = st_reg.cfg.hdr_len;
      st_next.res.next_sel = st_reg.cfg.next_sel;
      st_next.res.sum_zero = st_reg.cfg.zero_en;
      st_next.res.sum_fixup = st_reg.cfg.fixup_en;
      // position only means something for ipv4 headers
      st_next.res.sum_pos = (st_reg.cfg.mode == MODE_V4) ? st_reg.cfg.sum_pos : 8'h00;
      st_next.res.sum_len = st_reg.cfg.sum_len;
    end
  end

  // ==========================================================
  // registers; clock enable freezes everything including the bus
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
      st_reg.cfg.sum_len <= RST_SLEN;
      st_reg.cfg.next_sel <= RST_NEXT;
    end else if (ce_i) begin
      st_reg <= st_next;
    end
  end

  assign wb_dat_o = st_reg.dat;
  assign wb_ack_o = st_reg.ack;
  assign res_o = st_reg.res;

  // ==========================================================
  // checks
  property p_v4_version;
    @(posedge clk_i) disable iff (rst_i)
    ce_i && hdr_valid_i && st_reg.cfg.mode == MODE_V4 && hdr_i[7:4] != VER_V4 |=> !res_o.proto_ok;
  endproperty
  a_v4_version: assert property (p_v4_version) else $error("ipv4 accepted with wrong version");

  property p_v6_version;
    @(posedge clk_i) disable iff (rst_i)
    ce_i && hdr_valid_i && st_reg.cfg.mode == MODE_V6 && hdr_i[7:4] != VER_V6 |=> !res_o.proto_ok;
  endproperty
  a_v6_version: assert property (p_v6_version) else $error("ipv6 accepted with wrong version");

  property p_generic_open;
    @(posedge clk_i) disable iff (rst_i)
    ce_i && hdr_valid_i && !is_ip && st_reg.cfg.mask_a == 8'h00 && st_reg.cfg.mask_b == 64'h0
      |=> res_o.proto_ok;
  endproperty
  a_generic_open: assert property (p_generic_open) else $error("generic mode refused open header");

  property p_fragment;
    @(posedge clk_i) disable iff (rst_i)
    ce_i && hdr_valid_i && st_reg.cfg.mode == MODE_V4 && hdr_i[8*FRAG_BYTE+MF_BIT] |=> !res_o.proto_ok;
  endproperty
  a_fragment: assert property (p_fragment) else $error("ipv4 fragment accepted");

  property p_hit_needs_proto;
    @(posedge clk_i) disable iff (rst_i)
    res_o.hit != '0 |-> res_o.proto_ok;
  endproperty
  a_hit_needs_proto: assert property (p_hit_needs_proto) else $error("flow hit without valid protocol");

  property p_hit_channel;
    @(posedge clk_i) disable iff (rst_i)
    ce_i && hdr_valid_i && !st_reg.flow[0].chan_en[chan_i] |=> !res_o.hit[0];
  endproperty
  a_hit_channel: assert property (p_hit_channel) else $error("flow hit on disabled channel");

  property p_length;
    @(posedge clk_i) disable iff (rst_i)
    res_o.valid |-> res_o.hdr_len == $past(st_reg.cfg.hdr_len) && res_o.next_sel == $past(st_reg.cfg.next_sel);
  endproperty
  a_length: assert property (p_length) else $error("length or next stage not forwarded");

  property p_sum_pos;
    @(posedge clk_i) disable iff (rst_i)
    ce_i && hdr_valid_i && st_reg.cfg.mode != MODE_V4 |=> res_o.sum_pos == 8'h00;
  endproperty
  a_sum_pos: assert property (p_sum_pos) else $error("checksum position outside ipv4");

  property p_ack_pulse;
    @(posedge clk_i) disable iff (rst_i)
    ce_i && wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held longer than one cycle");
endmodule
`default_nettype wire

//--- hcmp_far_stage.sv
// preceding analyzer stage: hands one header window per request to the comparator
// assumes the bench calls send from a single process, one request at a time
`timescale 1ns/1ps
`default_nettype none
module hcmp_far_stage
  import hcmp_pkg::*;
(
  input wire logic clk_i,
  output logic hdr_valid_o,
  output logic [HDR_W-1:0] hdr_o,
  output logic [$clog2(CHANS)-1:0] chan_o
);
  logic pend = 1'b0;
  logic [HDR_W-1:0] p_hdr;
  logic [$clog2(CHANS)-1:0] p_chan;
  initial begin
    hdr_valid_o = 1'b0;
    hdr_o = '0;
    chan_o = '0;
  end
  // ==========================================================
  // launch on the rising edge; outside a pulse the window is scrambled
  // so a stale header can never pass for a fresh one
  always @(posedge clk_i) begin
    hdr_valid_o <= pend;
    hdr_o <= pend ? p_hdr : ~hdr_o;
    chan_o <= pend ? p_chan : ~chan_o;
    pend <= 1'b0;
  end
  // ==========================================================
  // mailbox filled mid-cycle, so requests may follow every cycle
  task automatic send(input logic [HDR_W-1:0] h, input logic [$clog2(CHANS)-1:0] c);
    @(negedge clk_i);
    p_hdr = h;
    p_chan = c;
    pend = 1'b1;
    @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

//--- hcmp_pkg.sv
// constants, field layouts and carrier types of the header comparator stage
// assumes a 32-bit wishbone register bus and a header window presented whole
`default_nettype none
package hcmp_pkg;
  // ==========================================================
  // sizes
  localparam int HDR_BYTES = 136;
  localparam int HDR_W = HDR_BYTES * 8;
  localparam int FLOWS = 2;
  localparam int CHANS = 2;
  localparam int NARROW_BYTES = 4;
  localparam int WIDE_BYTES = 16;
  localparam int B_BYTES = 8;
  // ==========================================================
  // comparator modes and header constants
  localparam logic [1:0] MODE_V4 = 2'h0;
  localparam logic [1:0] MODE_V6 = 2'h1;
  localparam logic [1:0] MODE_G32 = 2'h2;
  localparam logic [1:0] MODE_G128 = 2'h3;
  localparam logic [3:0] VER_V4 = 4'h4;
  localparam logic [3:0] VER_V6 = 4'h6;
  localparam int FRAG_BYTE = 6;
  localparam int MF_BIT = 5;
  localparam logic [1:0] SEL_SRC = 2'h0;
  localparam logic [1:0] SEL_DST = 2'h1;
  localparam logic [1:0] SEL_ANY = 2'h2;
  // ==========================================================
  // register offsets (byte addresses) and field positions
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_POS = 8'h04;
  localparam logic [7:0] A_PRA = 8'h08;
  localparam logic [7:0] A_SUMP = 8'h0c;
  localparam logic [7:0] A_MBL = 8'h10;
  localparam logic [7:0] A_MBH = 8'h14;
  localparam logic [7:0] A_KBL = 8'h18;
  localparam logic [7:0] A_KBH = 8'h1c;
  localparam logic [7:0] A_STAT = 8'h20;
  localparam int F_MATCH_W = 4;
  localparam int F_MASK_W = 8;
  localparam int C_MODE = 0;
  localparam int C_ZERO = 2;
  localparam int C_FIX = 3;
  localparam int C_SLEN = 4;
  localparam int C_NEXT = 8;
  localparam int P_A = 0;
  localparam int P_B = 8;
  localparam int P_FLOW = 16;
  localparam int P_HLEN = 24;
  localparam int R_MATCH = 0;
  localparam int R_MASK = 8;
  localparam int F_ENA = 0;
  localparam int F_SEL = 1;
  localparam int F_CHAN = 3;
  localparam int S_VALID = 0;
  localparam int S_PROTO = 1;
  localparam int S_NEXT = 2;
  localparam int S_HIT = 4;
  // ==========================================================
  // reset values
  localparam logic [1:0] RST_SLEN = 2'h2;
  localparam logic [2:0] RST_NEXT = 3'h5;
  // ==========================================================
  // carriers
  typedef struct packed {
    logic [1:0] mode;
    logic [7:0] match_a;
    logic [7:0] mask_a;
    logic [4:0] pos_a;
    logic [63:0] match_b;
    logic [63:0] mask_b;
    logic [6:0] pos_b;
    logic [7:0] hdr_len;
    logic [2:0] next_sel;
    logic [4:0] flow_pos;
    logic zero_en;
    logic fixup_en;
    logic [7:0] sum_pos;
    logic [1:0] sum_len;
  } hcmp_cfg_t;
  typedef struct packed {
    logic ena;
    logic [1:0] sel;
    logic [CHANS-1:0] chan_en;
    logic [127:0] match;
    logic [127:0] mask;
  } hcmp_flow_t;
  typedef struct packed {
    logic valid;
    logic proto_ok;
    logic next_ok;
    logic [FLOWS-1:0] hit;
    logic [7:0] hdr_len;
    logic [2:0] next_sel;
    logic sum_zero;
    logic sum_fixup;
    logic [7:0] sum_pos;
    logic [1:0] sum_len;
  } hcmp_res_t;
endpackage
`default_nettype wire

//--- tb_top.sv
// self-checking bench of the header comparator stage against a behavioural model
// assumes hcmp_pkg, hcmp_comparator and hcmp_far_stage are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import hcmp_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic hv;
  logic [HDR_W-1:0] hdr;
  logic [$clog2(CHANS)-1:0] chan;
  hcmp_res_t res;
  int errors = 0;
  int checked = 0;
  logic [31:0] regs [int];
  hcmp_res_t expq [$];
  // ==========================================================
  // clock and instances
  always #20 clk_i = ~clk_i;
  hcmp_comparator i_hcmp_comparator (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .hdr_valid_i(hv), .hdr_i(hdr), .chan_i(chan), .res_o(res));
  hcmp_far_stage i_hcmp_far_stage (.clk_i(clk_i), .hdr_valid_o(hv), .hdr_o(hdr), .chan_o(chan));
  // ==========================================================
  // comparisons and closing
  task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_r(input hcmp_res_t got, input hcmp_res_t exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ==========================================================
  // register map: implemented bits per word address, zero when unmapped
  function automatic logic [31:0] rmask(input logic [7:0] a);
    if (a == A_CTRL) return 32'h0000073f;
    if (a == A_POS) return 32'hff1f7f1f;
    if (a == A_PRA) return 32'h0000ffff;
    if (a == A_SUMP) return 32'h000000ff;
    if (a inside {A_MBL, A_MBH, A_KBL, A_KBH}) return 32'hffffffff;
    if (a[7:6] inside {2'h1, 2'h2} && a[1:0] == 2'h0) begin
      if (a[5:0] == 6'h00) return 32'h0000001f;
      if (a[5:4] inside {2'h1, 2'h2}) return 32'hffffffff;
    end
    return 32'h0;
  endfunction
  // classic single cycle; the wait is bounded only by the bench's own limit
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    dat <= d;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (w) regs[a] = d & rmask(a);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk_w(q, regs.exists(a) ? regs[a] : 32'h0);
  endtask
  // ==========================================================
  // behavioural model; multi-byte fields are taken first byte most significant
  function automatic logic [127:0] fld(input logic [HDR_W-1:0] h, input int p, input int n);
    logic [127:0] v;
    v = '0;
    for (int k = 0; k < n; k++) begin
      v = {v[119:0], (p + k < HDR_BYTES) ? h[8*(p+k) +: 8] : 8'h00};
    end
    return v;
  endfunction
  function automatic hcmp_res_t model(input logic [HDR_W-1:0] h, input int c);
    hcmp_res_t r;
    logic [31:0] ct;
    logic [31:0] ps;
    logic [127:0] mt;
    logic [127:0] mk;
    logic ok;
    logic hitv;
    int b;
    int nb;
    int dof;
    ct = regs[A_CTRL];
    ps = regs[A_POS];
    r = '0;
    r.valid = 1'b1;
    ok = 1'b1;
    if (ct[1:0] == MODE_V4) ok = h[7:4] == VER_V4 && h[53:48] == 6'h00 && h[63:56] == 8'h00;
    if (ct[1:0] == MODE_V6) ok = h[7:4] == VER_V6;
    ok &= ((h[8*ps[4:0] +: 8] ^ regs[A_PRA][7:0]) & regs[A_PRA][15:8]) == 8'h00;
    ok &= ((fld(h, ps[14:8], 8) ^ {regs[A_MBH], regs[A_MBL]}) & {regs[A_KBH], regs[A_KBL]}) == 0;
    r.proto_ok = ok;
    r.next_sel = ct[10:8];
    r.next_ok = ct[10:8] inside {3'h1, 3'h2, 3'h3, 3'h5};
    r.hdr_len = ps[31:24];
    r.sum_zero = ct[2];
    r.sum_fixup = ct[3];
    r.sum_len = ct[5:4];
    r.sum_pos = ct[1:0] == MODE_V4 ? regs[A_SUMP][7:0] : 8'h00;
    nb = ct[1:0] inside {MODE_V4, MODE_G32} ? NARROW_BYTES : WIDE_BYTES;
    dof = ct[1:0] == MODE_V4 ? 4 : 16;
    for (int f = 0; f < FLOWS; f++) begin
      b = 64 * (f + 1);
      mt = {regs[b+28], regs[b+24], regs[b+20], regs[b+16]} >> (nb == 4 ? 96 : 0);
      mk = {regs[b+44], regs[b+40], regs[b+36], regs[b+32]} >> (nb == 4 ? 96 : 0);
      hitv = 1'b0;
      if (ct[1] || regs[b][2:1] inside {SEL_SRC, SEL_ANY}) hitv |= ((fld(h, ps[20:16], nb) ^ mt) & mk) == 0;
      if (!ct[1] && regs[b][2:1] inside {SEL_DST, SEL_ANY}) hitv |= ((fld(h, ps[20:16] + dof, nb) ^ mt) & mk) == 0;
      r.hit[f] = hitv & ok & regs[b][0] & regs[b][3+c];
    end
    return r;
  endfunction
  // ==========================================================
  // every result pulse is matched against the oldest prediction
  always @(posedge clk_i) begin
    if (res.valid === 1'b1) begin
      chk_r(res, expq.size() > 0 ? expq.pop_front() : hcmp_res_t'(0));
    end
  end
  // ==========================================================
  // random stimulus: fields copied from the header, then sometimes spoiled
  function automatic logic [127:0] spoil();
    return $urandom_range(3) == 0 ? {$urandom, $urandom, $urandom, $urandom} : 128'h0;
  endfunction
  function automatic logic [127:0] rmsk();
    return $urandom_range(3) == 0 ? 128'h0 : {$urandom, $urandom, $urandom, $urandom};
  endfunction
  task automatic trial();
    logic [HDR_W-1:0] h;
    logic [HDR_W-1:0] h2;
    logic [31:0] ct;
    logic [31:0] ps;
    logic [31:0] fc;
    logic [127:0] v;
    logic [127:0] k;
    logic c;
    hcmp_res_t r;
    int b;
    for (int i = 0; i < HDR_W / 32; i++) h[32*i +: 32] = $urandom;
    ct = $urandom & 32'h0000073f;
    if (ct[2]) ct[3] = 1'b0;
    if ($urandom_range(3) != 0) h[7:4] = ct[0] ? VER_V6 : VER_V4;
    if ($urandom_range(3) != 0) h[63:48] = h[63:48] & 16'h00c0;
    ps = $urandom & 32'hff1f7f1f;
    wr(A_CTRL, ct);
    wr(A_POS, ps);
    wr(A_PRA, {16'h0, 8'(rmsk() >> 120), h[8*ps[4:0] +: 8] ^ 8'(spoil() >> 120)});
    v = fld(h, ps[14:8], 8) ^ spoil();
    k = rmsk();
    wr(A_MBL, v[31:0]);
    wr(A_MBH, v[63:32]);
    wr(A_KBL, k[31:0]);
    wr(A_KBH, k[63:32]);
    wr(A_SUMP, $urandom);
    for (int f = 0; f < FLOWS; f++) begin
      b = 64 * (f + 1);
      fc = $urandom & 32'h1f;
      v = fld(h, ps[20:16] + ((!ct[1] && fc[2:1] == SEL_DST) ? (ct[0] ? 16 : 4) : 0), ct[0] ? 16 : 4);
      if (!ct[0]) v = {v[31:0], $urandom, $urandom, $urandom};
      v ^= spoil();
      k = rmsk();
      wr(8'(b), fc);
      for (int w = 0; w < 4; w++) begin
        wr(8'(b + 16 + 4 * w), v[32*w +: 32]);
        wr(8'(b + 32 + 4 * w), k[32*w +: 32]);
      end
    end
    c = 1'($urandom);
    h2 = h;
    h2[8*$urandom_range(HDR_BYTES - 1) +: 8] = 8'($urandom);
    // three headers back to back, the last one with one byte changed
    expq.push_back(model(h, c));
    i_hcmp_far_stage.send(h, c);
    expq.push_back(model(h, !c));
    i_hcmp_far_stage.send(h, !c);
    r = model(h2, c);
    expq.push_back(r);
    i_hcmp_far_stage.send(h2, c);
    // status word is read while the last result still stands
    regs[A_STAT] = {26'h0, r.hit, 1'b0, r.next_ok, r.proto_ok, 1'b1};
    rd(A_STAT);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(32'hd63c0378));
    for (int a = 0; a < 256; a += 4) begin
      if (rmask(8'(a)) != 32'h0) regs[a] = 32'h0;
    end
    regs[A_CTRL] = {21'h0, RST_NEXT, 2'h0, RST_SLEN, 4'h0};
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int a = 0; a < 256; a += 4) rd(8'(a));
    for (int a = 0; a < 256; a += 4) begin
      wr(8'(a), $urandom & (a == 0 ? 32'hfffffff7 : 32'hffffffff));
      rd(8'(a));
    end
    for (int t = 0; t < 150; t++) trial();
    // frozen stage: a header offered while disabled must not be taken
    repeat (4) @(posedge clk_i);
    ce_i <= 1'b0;
    i_hcmp_far_stage.send({HDR_W{1'b0}}, 1'b0);
    repeat (2) @(posedge clk_i);
    ce_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk_w(32'(expq.size()), 32'h0);
    end_sim();
  end
  // hang guard, well past the expected run length
  initial begin
    repeat (60000) @(posedge clk_i);
    errors++;
    end_sim();
  end
endmodule
`default_nettype wire
